// ===== logic/ucb_map.vh
// Register offsets, field positions, reset values and timing counts of the serial port block
`ifndef UCB_MAP_VH
`define UCB_MAP_VH
`define UCB_OFF_CTRL 12'h098
`define UCB_OFF_PWR 12'h09C
`define UCB_OFF_TIMER_MODE_REG 12'h0A0
`define UCB_OFF_RELOAD 12'h0A4
`define UCB_OFF_TXDATA 12'h0A8
`define UCB_OFF_RXDATA 12'h0AC
`define UCB_OFF_ISTAT 12'h0B0
`define UCB_OFF_IMASK 12'h0B4
`define UCB_CTRL_RESET 8'h00
`define UCB_BIT_MSU 7
`define UCB_BIT_MSL 6
`define UCB_BIT_MPF 5
`define UCB_BIT_REN 4
`define UCB_BIT_TB8 3
`define UCB_BIT_RB8 2
`define UCB_BIT_TI 1
`define UCB_BIT_RI 0
`define UCB_PWR_BDBL 7
`define UCB_PWR_FEVS 6
`define UCB_MODE0 2'h0
`define UCB_MODE1 2'h1
`define UCB_MODE2 2'h2
`define UCB_MODE3 2'h3
`define UCB_DIV_M0 8'h06
`define UCB_DIV_M2_SLOW 8'h20
`define UCB_DIV_M2_FAST 8'h10
`define UCB_T1_PRESCALE 8'h06
`define UCB_OVF_SLOW 5'h10
`define UCB_OVF_FAST 5'h08
`define UCB_SAMPLES 5'h10
`define UCB_MID_A 4'h7
`define UCB_MID_B 4'h8
`define UCB_MID_C 4'h9
`define UCB_TIMER_MODE_REG_ONESHOT_13 2'h0
`define UCB_TIMER_MODE_REG_16 2'h1
`define UCB_TIMER_MODE_REG_RELOAD 2'h2
`define UCB_TIMER_MODE_REG_STOP 2'h3
`define UCB_IRQ_W 3
`define UCB_IRQ_TX 0
`define UCB_IRQ_RX 1
`define UCB_IRQ_FE 2
`endif

// ===== logic/ucb_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module ucb_sync (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Pin and filtered level
  input wire pin,
  output reg level
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      level <= 1'b1;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // Only a change seen by two later stages counts
      if (s2_r == s3_r) begin
        level <= s3_r;
      end
    end
  end
endmodule // ucb_sync
`default_nettype wire

// ===== logic/ucb_baud.v
// Bit-rate tick generator: fixed divisors and a timer 1 overflow source
`timescale 1ns/10ps
`default_nettype none
`include "ucb_map.vh"
module ucb_baud (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Configuration
  input wire [1:0] mode,
  input wire baud_double,
  input wire [1:0] t1_mode,
  input wire t1_counter,
  input wire t1_ext_tick,
  input wire [7:0] timer1_reload_value,
  // Tick out: mode 0 bit rate or 16x sample rate otherwise
  output reg tick,
  output reg t1_ovf
);
  reg [7:0] pre_r;
  reg [7:0] div_r;
  reg [15:0] t1_r;
  reg [4:0] ovf_r;
  reg [7:0] fdiv;
  wire t1_inc;
  wire [4:0] ovf_lim;
  reg t1_wrap;
  assign t1_inc = t1_counter ? t1_ext_tick : (pre_r == `UCB_T1_PRESCALE - 8'h01);
  assign ovf_lim = baud_double ? `UCB_OVF_FAST : `UCB_OVF_SLOW;
  always @* begin
    fdiv = `UCB_DIV_M0;
    if (mode == `UCB_MODE2) begin
      fdiv = baud_double ? `UCB_DIV_M2_FAST : `UCB_DIV_M2_SLOW;
    end
    case (t1_mode)
      `UCB_TIMER_MODE_REG_ONESHOT_13: t1_wrap = (t1_r[12:0] == 13'h1FFF);
      `UCB_TIMER_MODE_REG_16: t1_wrap = (t1_r == 16'hFFFF);
      `UCB_TIMER_MODE_REG_RELOAD: t1_wrap = (t1_r[7:0] == 8'hFF);
      default: t1_wrap = 1'b0;
    endcase
  end
  // Mode 2 ticks 16 times per bit, so divide by one sixteenth of the bit divisor
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre_r <= 8'h00;
      div_r <= 8'h00;
      t1_r <= 16'h0000;
      ovf_r <= 5'h00;
      tick <= 1'b0;
      t1_ovf <= 1'b0;
    end else begin
      pre_r <= (pre_r == `UCB_T1_PRESCALE - 8'h01) ? 8'h00 : pre_r + 8'h01;
      t1_ovf <= 1'b0;
      tick <= 1'b0;
      if (t1_inc && t1_mode != `UCB_TIMER_MODE_REG_STOP) begin
        if (t1_wrap) begin
          t1_ovf <= 1'b1;
          t1_r <= (t1_mode == `UCB_TIMER_MODE_REG_RELOAD) ? {8'h00, timer1_reload_value} : 16'h0000;
        end else begin
          t1_r <= t1_r + 16'h0001;
        end
      end
      if (mode == `UCB_MODE1 || mode == `UCB_MODE3) begin
        // 16x rate is overflow/2 or overflow/1, so a bit is ovf/32 or ovf/16
        if (t1_ovf) begin
          if (ovf_r >= (ovf_lim >> 3) - 5'h01) begin
            ovf_r <= 5'h00;
            tick <= 1'b1;
          end else begin
            ovf_r <= ovf_r + 5'h01;
          end
        end
        div_r <= 8'h00;
      end else begin
        ovf_r <= 5'h00;
        if (mode == `UCB_MODE0) begin
          div_r <= (div_r >= fdiv - 8'h01) ? 8'h00 : div_r + 8'h01;
          tick <= (div_r >= fdiv - 8'h01);
        end else begin
          div_r <= (div_r >= (fdiv >> 4) - 8'h01) ? 8'h00 : div_r + 8'h01;
          tick <= (div_r >= (fdiv >> 4) - 8'h01);
        end
      end
    end
  end
endmodule // ucb_baud
`default_nettype wire

// ===== logic/ucb_uart.v
// Serial port control, status, baud selection and framing with an APB register slave
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ucb_map.vh"
module ucb_uart (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Serial pins; in mode 0 rxd is two-way
  input wire rxd_in,
  output reg rxd_out,
  output reg rxd_oe,
  output reg txd,
  // Timer 1 external count input
  input wire t1_pin,
  // Interrupt
  output wire irq
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_START = 4'b0010;
  localparam ST_DATA = 4'b0100;
  localparam ST_STOP = 4'b1000;

  ////////////////////////////////////////////////////////////////////////
  reg mode_select_upper_r;
  reg mode_select_lower_r;
  reg multiproc_filter_r;
  reg rx_enable_r;
  reg tx_ninth_bit_r;
  reg rx_ninth_bit_r;
  reg tx_done_flag_r;
  reg rx_done_flag_r;
  reg framing_error_flag_r;
  reg baud_double_r;
  reg fe_view_select_r;
  reg [3:0] timer_mode_reg_r;
  reg [7:0] timer1_reload_value_r;
  reg [7:0] rx_buf_r;
  reg [`UCB_IRQ_W-1:0] istat_r;
  reg [`UCB_IRQ_W-1:0] imask_r;
  wire rxd_s;
  wire t1_s;
  reg t1_s_d_r;
  wire tick;
  wire t1_ovf;
  wire [1:0] mode;
  wire wr_en;
  wire rd_en;
  reg [7:0] ctrl_view;
  assign mode = {mode_select_upper_r, mode_select_lower_r};
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign irq = |(istat_r & imask_r);

  ucb_sync u_rx_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(rxd_in),
    .level(rxd_s)
  );
  ucb_sync u_t1_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(t1_pin),
    .level(t1_s)
  );
  ucb_baud u_baud (
    .ref_clk(ref_clk),
    .rst(rst),
    .mode(mode),
    .baud_double(baud_double_r),
    .t1_mode(timer_mode_reg_r[1:0]),
    .t1_counter(timer_mode_reg_r[2]),
    .t1_ext_tick(t1_s_d_r & ~t1_s),
    .timer1_reload_value(timer1_reload_value_r),
    .tick(tick),
    .t1_ovf(t1_ovf)
  );

  ////////////////////////////////////////////////////////////////////////
  // Transmitter: modes 1-3 send start, 8 data, optional ninth, stop; mode 0 sends the 8 data bits alone
  reg [3:0] tx_st_r;
  reg [8:0] tx_sh_r;
  reg [3:0] tx_cnt_r;
  reg [3:0] tx_sub_r;
  reg tx_pend_r;
  reg tx_done_set;
  wire tx_wr;
  wire nine_bit;
  wire bit_tick;
  assign tx_wr = wr_en && paddr == `UCB_OFF_TXDATA;
  assign nine_bit = mode_select_upper_r;
  // In modes 1-3 the tick is 16x the bit rate
  assign bit_tick = tick && (mode == `UCB_MODE0 || tx_sub_r == 4'hF);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_st_r <= ST_IDLE;
      tx_sh_r <= 9'h1FF;
      tx_cnt_r <= 4'h0;
      tx_sub_r <= 4'h0;
      tx_pend_r <= 1'b0;
      txd <= 1'b1;
      tx_done_set <= 1'b0;
    end else begin
      tx_done_set <= 1'b0;
      if (tick) begin
        tx_sub_r <= tx_sub_r + 4'h1;
      end
      if (tx_wr) begin
        tx_pend_r <= 1'b1;
        tx_sh_r <= {tx_ninth_bit_r | ~nine_bit, pwdata[7:0]};
      end
      case (tx_st_r)
        ST_IDLE: begin
          txd <= 1'b1;
          tx_cnt_r <= 4'h0;
          if (tx_pend_r && bit_tick) begin
            tx_pend_r <= 1'b0;
            tx_st_r <= (mode == `UCB_MODE0) ? ST_DATA : ST_START;
            txd <= (mode == `UCB_MODE0) ? 1'b1 : 1'b0;
          end
        end
        ST_START: begin
          if (bit_tick) begin
            txd <= tx_sh_r[0];
            tx_sh_r <= {1'b1, tx_sh_r[8:1]};
            tx_st_r <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (bit_tick) begin
            tx_cnt_r <= tx_cnt_r + 4'h1;
            if (tx_cnt_r == ((nine_bit || mode == `UCB_MODE0) ? 4'h8 : 4'h7)) begin
              txd <= 1'b1;
              tx_st_r <= (mode == `UCB_MODE0) ? ST_IDLE : ST_STOP;
              tx_done_set <= (mode == `UCB_MODE0);
            end else begin
              txd <= tx_sh_r[0];
              tx_sh_r <= {1'b1, tx_sh_r[8:1]};
            end
          end
        end
        ST_STOP: begin
          if (bit_tick) begin
            tx_st_r <= ST_IDLE;
            tx_done_set <= 1'b1;
          end
        end
        default: tx_st_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver: modes 1-3 oversample 16x with 2-of-3 majority at samples 7, 8, 9; mode 0 takes one sample per tick
  reg [3:0] rx_st_r;
  reg [3:0] rx_ph_r;
  reg [3:0] rx_cnt_r;
  reg [8:0] rx_sh_r;
  reg [2:0] rx_vote_r;
  reg rxd_d_r;
  reg rx_done_set;
  reg fe_set;
  reg rx_load;
  reg [7:0] rx_data_nxt;
  reg rx_nine_nxt;
  wire vote;
  wire [8:0] rx_frame;
  assign vote = (rx_vote_r[0] & rx_vote_r[1]) | (rx_vote_r[0] & rx_vote_r[2]) | (rx_vote_r[1] & rx_vote_r[2]);
  assign rx_frame = {vote, rx_sh_r[8:1]};

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_st_r <= ST_IDLE;
      rx_ph_r <= 4'h0;
      rx_cnt_r <= 4'h0;
      rx_sh_r <= 9'h1FF;
      rx_vote_r <= 3'h7;
      rxd_d_r <= 1'b1;
      rx_done_set <= 1'b0;
      fe_set <= 1'b0;
      rx_load <= 1'b0;
      rx_data_nxt <= 8'h00;
      rx_nine_nxt <= 1'b0;
      rxd_out <= 1'b1;
      rxd_oe <= 1'b0;
      t1_s_d_r <= 1'b1;
    end else begin
      t1_s_d_r <= t1_s;
      rxd_d_r <= rxd_s;
      rx_done_set <= 1'b0;
      fe_set <= 1'b0;
      rx_load <= 1'b0;
      // Mode 0 drives data out on the two-way pin during a send
      rxd_oe <= (mode == `UCB_MODE0) && (tx_st_r == ST_DATA);
      rxd_out <= txd;
      if (tick) begin
        rx_ph_r <= rx_ph_r + 4'h1;
        if (rx_ph_r == `UCB_MID_A || rx_ph_r == `UCB_MID_B || rx_ph_r == `UCB_MID_C) begin
          rx_vote_r <= {rx_vote_r[1:0], rxd_s};
        end
      end
      case (rx_st_r)
        ST_IDLE: begin
          rx_cnt_r <= 4'h0;
          if (mode == `UCB_MODE0) begin
            // Mode 0 receives once enabled and the flag is clear
            if (rx_enable_r && !rx_done_flag_r && tick) begin
              rx_st_r <= ST_DATA;
            end
          end else if (rx_enable_r && rxd_d_r && !rxd_s) begin
            rx_ph_r <= 4'h0;
            rx_sh_r <= 9'h1FF;
            rx_st_r <= ST_START;
          end
        end
        ST_START: begin
          if (tick && rx_ph_r == 4'hF) begin
            // False start bits are dropped
            rx_st_r <= vote ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (mode == `UCB_MODE0) begin
            if (tick) begin
              rx_sh_r <= {rxd_s, rx_sh_r[8:1]};
              rx_cnt_r <= rx_cnt_r + 4'h1;
              if (rx_cnt_r == 4'h7) begin
                rx_st_r <= ST_IDLE;
                rx_load <= 1'b1;
                rx_data_nxt <= {rxd_s, rx_sh_r[8:2]};
                rx_nine_nxt <= rx_ninth_bit_r;
              end
            end
          end else if (tick && rx_ph_r == 4'hF) begin
            rx_sh_r <= rx_frame;
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r == (nine_bit ? 4'h8 : 4'h7)) begin
              rx_st_r <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (tick && rx_ph_r == 4'hF) begin
            rx_st_r <= ST_IDLE;
            fe_set <= ~vote;
            if (!rx_done_flag_r) begin
              if (nine_bit) begin
                rx_load <= !multiproc_filter_r || rx_sh_r[8];
                rx_data_nxt <= rx_sh_r[7:0];
                rx_nine_nxt <= rx_sh_r[8];
              end else begin
                rx_load <= !multiproc_filter_r || vote;
                rx_data_nxt <= rx_sh_r[8:1];
                rx_nine_nxt <= vote;
              end
            end
          end
        end
        default: rx_st_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers; hardware sets beat software clears in the same cycle
  wire ctrl_wr;
  wire [7:0] wd;
  assign ctrl_wr = wr_en && paddr == `UCB_OFF_CTRL;
  assign wd = pwdata[7:0];

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_select_upper_r <= 1'b0;
      mode_select_lower_r <= 1'b0;
      multiproc_filter_r <= 1'b0;
      rx_enable_r <= 1'b0;
      tx_ninth_bit_r <= 1'b0;
      rx_ninth_bit_r <= 1'b0;
      tx_done_flag_r <= 1'b0;
      rx_done_flag_r <= 1'b0;
      framing_error_flag_r <= 1'b0;
      baud_double_r <= 1'b0;
      fe_view_select_r <= 1'b0;
      timer_mode_reg_r <= 4'h0;
      timer1_reload_value_r <= 8'h00;
      rx_buf_r <= 8'h00;
      istat_r <= {`UCB_IRQ_W{1'b0}};
      imask_r <= {`UCB_IRQ_W{1'b0}};
    end else begin
      if (ctrl_wr) begin
        if (fe_view_select_r) begin
          framing_error_flag_r <= wd[`UCB_BIT_MSU];
        end else begin
          mode_select_upper_r <= wd[`UCB_BIT_MSU];
        end
        mode_select_lower_r <= wd[`UCB_BIT_MSL];
        multiproc_filter_r <= wd[`UCB_BIT_MPF];
        rx_enable_r <= wd[`UCB_BIT_REN];
        tx_ninth_bit_r <= wd[`UCB_BIT_TB8];
        rx_ninth_bit_r <= wd[`UCB_BIT_RB8];
        tx_done_flag_r <= wd[`UCB_BIT_TI];
        rx_done_flag_r <= wd[`UCB_BIT_RI];
      end
      if (wr_en && paddr == `UCB_OFF_PWR) begin
        baud_double_r <= wd[`UCB_PWR_BDBL];
        fe_view_select_r <= wd[`UCB_PWR_FEVS];
      end
      if (wr_en && paddr == `UCB_OFF_TIMER_MODE_REG) begin
        timer_mode_reg_r <= wd[7:4];
      end
      if (wr_en && paddr == `UCB_OFF_RELOAD) begin
        timer1_reload_value_r <= wd;
      end
      if (wr_en && paddr == `UCB_OFF_IMASK) begin
        imask_r <= wd[`UCB_IRQ_W-1:0];
      end
      if (rd_en && paddr == `UCB_OFF_ISTAT) begin
        // Clear only what the read returned, so an event in the setup cycle survives
        istat_r <= istat_r & ~prdata[`UCB_IRQ_W-1:0];
      end
      // Hardware only ever sets flags here; clearing is software's job
      if (tx_done_set) begin
        tx_done_flag_r <= 1'b1;
        istat_r[`UCB_IRQ_TX] <= 1'b1;
      end
      if (rx_load) begin
        rx_done_flag_r <= 1'b1;
        rx_buf_r <= rx_data_nxt;
        rx_ninth_bit_r <= rx_nine_nxt;
        istat_r[`UCB_IRQ_RX] <= 1'b1;
      end
      if (fe_set) begin
        framing_error_flag_r <= 1'b1;
        istat_r[`UCB_IRQ_FE] <= 1'b1;
      end
    end
  end

  always @* begin
    ctrl_view = {fe_view_select_r ? framing_error_flag_r : mode_select_upper_r,
      mode_select_lower_r, multiproc_filter_r, rx_enable_r, tx_ninth_bit_r,
      rx_ninth_bit_r, tx_done_flag_r, rx_done_flag_r};
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `UCB_OFF_CTRL: prdata <= {24'h000000, ctrl_view};
        `UCB_OFF_PWR: prdata <= {24'h000000, baud_double_r, fe_view_select_r, 6'h00};
        `UCB_OFF_TIMER_MODE_REG: prdata <= {24'h000000, timer_mode_reg_r, 4'h0};
        `UCB_OFF_RELOAD: prdata <= {24'h000000, timer1_reload_value_r};
        `UCB_OFF_RXDATA: prdata <= {24'h000000, rx_buf_r};
        `UCB_OFF_ISTAT: prdata <= {29'h0000000, istat_r};
        `UCB_OFF_IMASK: prdata <= {29'h0000000, imask_r};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule // ucb_uart
`default_nettype wire

// ===== test/ucb_uart_checker.sv
// Port-level assertions for the serial port block
`timescale 1ns/10ps
`default_nettype none
`include "ucb_map.vh"
module ucb_uart_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Serial pins, timer input, interrupt
  input wire logic rxd_in,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  input wire logic txd,
  input wire logic t1_pin,
  input wire logic irq
);
  logic msu_r, msl_r, bdbl_r, fevs_r, txd_r;
  logic [7:0] rld_r;
  logic [2:0] imsk_r;
  int cnt_r, bt;
  wire logic wr = psel && penable && pwrite && pready;
  wire logic rd = psel && penable && !pwrite;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Shadow of the configuration, snooped from the bus
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {msu_r, msl_r, bdbl_r, fevs_r} <= 4'h0;
      rld_r <= 8'h00;
      imsk_r <= 3'h0;
      txd_r <= 1'b1;
      cnt_r <= 0;
    end else begin
      txd_r <= txd;
      cnt_r <= (txd != txd_r) ? 1 : cnt_r + 1;
      if (wr && paddr == `UCB_OFF_CTRL) begin
        if (!fevs_r) msu_r <= pwdata[7];
        msl_r <= pwdata[6];
      end
      if (wr && paddr == `UCB_OFF_PWR) {bdbl_r, fevs_r} <= pwdata[7:6];
      if (wr && paddr == `UCB_OFF_RELOAD) rld_r <= pwdata[7:0];
      if (wr && paddr == `UCB_OFF_IMASK) imsk_r <= pwdata[2:0];
    end
  end
  // Bit time in clocks; the variable modes assume the auto-reload timer
  always_comb begin
    if (msu_r && !msl_r) bt = bdbl_r ? 16 : 32;
    else bt = (bdbl_r ? 96 : 192) * (256 - int'(rld_r));
  end
  ////////////////////////////////////////
  pready_a: assert property (psel && penable |-> pready && !pslverr)
    else $error("access not completed at once");
  upper_zero_a: assert property (rd |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  unmapped_a: assert property (rd && paddr == 12'h0C0 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  view_sel_a: assert property (rd && paddr == `UCB_OFF_CTRL && !fevs_r |-> prdata[7] == msu_r)
    else $error("bit 7 not the mode bit");
  oe_mode_a: assert property (rxd_oe |-> !msu_r && !msl_r)
    else $error("data pin driven outside mode 0");
  m0_rate_a: assert property ($changed(rxd_out) && rxd_oe |=> (!rxd_oe || $stable(rxd_out)) [*5])
    else $error("mode 0 bit shorter than six clocks");
  bit_rate_a: assert property ($rose(txd) && (msu_r || msl_r) |-> cnt_r % bt == 0)
    else $error("low run not whole bit times");
  irq_mask_a: assert property (irq |-> imsk_r != 3'h0)
    else $error("interrupt with all sources masked");
  cover property ($rose(irq));
  cover property ($fell(rxd_oe));
  cover property (rd && paddr == `UCB_OFF_CTRL && prdata[0]);
endmodule // ucb_uart_checker
`default_nettype wire

// ===== test/ucb_peer.sv
// Remote serial peer: sends frames on the receive line, samples the transmit line
`timescale 1ns/10ps
`default_nettype none
module ucb_peer (
  // Clock
  input wire logic ref_clk,
  // Serial lines
  input wire logic txd,
  output var logic rxd
);
  initial rxd = 1'b1;
  // Start, data LSB first, stop, then one idle bit so frames never abut
  task send(input int bt, input int n, input logic [8:0] d, input logic stp);
    int i;
    @(posedge ref_clk);
    rxd <= 1'b0;
    repeat (bt) @(posedge ref_clk);
    for (i = 0; i < n; i++) begin
      rxd <= d[i];
      repeat (bt) @(posedge ref_clk);
    end
    rxd <= stp;
    repeat (bt) @(posedge ref_clk);
    rxd <= 1'b1;
    repeat (bt) @(posedge ref_clk);
  endtask
  // Samples mid-bit; returns after the stop bit has ended
  task recv(input int bt, input int n, output logic [8:0] d);
    int i;
    d = 9'h000;
    @(negedge txd);
    repeat (bt / 2) @(posedge ref_clk);
    for (i = 0; i < n; i++) begin
      repeat (bt) @(posedge ref_clk);
      d[i] = txd;
    end
    repeat (2 * bt + 4) @(posedge ref_clk);
  endtask
endmodule // ucb_peer
`default_nettype wire

// ===== test/test_uart_control_and_baud_rate.sv
// Self-checking bench for the serial port control, status and baud block
`timescale 1ns/10ps
`default_nettype none
`include "ucb_map.vh"
module test_uart_control_and_baud_rate;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rv;
  logic [8:0] d9;
  logic [7:0] b8;
  logic t1_pin = 1'b1;
  logic t1_run = 1'b0;
  wire logic pready, pslverr, rxd_out, rxd_oe, txd, irq, p_rxd;
  wire logic [31:0] prdata;
  // Mode 0 turns the data pin round, so the wire follows whoever drives it
  wire logic rxd_in = rxd_oe ? rxd_out : p_rxd;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  ucb_uart u_ucb_uart (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .rxd_in, .rxd_out, .rxd_oe, .txd, .t1_pin, .irq);
  ucb_peer u_ucb_peer (.ref_clk, .txd, .rxd(p_rxd));
  always #2 ref_clk = ~ref_clk;
  // Counter source: one falling edge every 6 clocks, the same rate as timer operation
  always @(posedge ref_clk) begin
    if (t1_run && cyc % 3 == 0) begin
      t1_pin <= ~t1_pin;
    end
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      close_out;
    end
  end
  ////////////////////////////////////////
  task close_out;
    $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task ap(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    ap(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  ////////////////////////////////////////
  task t_regs;
    rdc(`UCB_OFF_CTRL, 32'h00);
    rdc(`UCB_OFF_PWR, 32'h00);
    ap(1'b1, 12'h0C0, 32'hFF);
    rdc(12'h0C0, 32'h00);
  endtask
  task t_view;
    ap(1'b1, `UCB_OFF_CTRL, 32'h80);
    rdc(`UCB_OFF_CTRL, 32'h80);
    ap(1'b1, `UCB_OFF_PWR, 32'h40);
    rdc(`UCB_OFF_CTRL, 32'h00);
    ap(1'b1, `UCB_OFF_CTRL, 32'h00);
    ap(1'b1, `UCB_OFF_PWR, 32'h00);
    rdc(`UCB_OFF_CTRL, 32'h80);
  endtask
  task t_m2(input logic dbl, input logic [7:0] c, input logic [7:0] dt);
    ap(1'b1, `UCB_OFF_PWR, {24'h0, dbl, 7'h0});
    ap(1'b1, `UCB_OFF_CTRL, {24'h0, c});
    ap(1'b1, `UCB_OFF_TXDATA, {24'h0, dt});
    u_ucb_peer.recv(dbl ? 16 : 32, 9, d9);
    chk({23'h0, d9}, {23'h0, c[3], dt});
    rdc(`UCB_OFF_CTRL, {24'h0, c | 8'h02});
  endtask
  task t_rx(input logic [7:0] c, input int n, input logic [8:0] d, input logic stp, input logic [7:0] e);
    ap(1'b1, `UCB_OFF_CTRL, {24'h0, c});
    u_ucb_peer.send(96, n, d, stp);
    repeat (8) @(posedge ref_clk);
    rdc(`UCB_OFF_CTRL, {24'h0, e});
  endtask
  task t_m3;
    // Timer 1 only feeds the rate; it has no interrupt source of its own
    ap(1'b1, `UCB_OFF_TIMER_MODE_REG, 32'h20);
    ap(1'b1, `UCB_OFF_RELOAD, 32'hFF);
    // The rate is only steady once the timer has reached its first reload
    repeat (1600) @(posedge ref_clk);
    ap(1'b1, `UCB_OFF_PWR, 32'h80);
    ap(1'b1, `UCB_OFF_IMASK, 32'h02);
    t_rx(8'hD0, 9, 9'h15A, 1'b1, 8'hD5);
    rdc(`UCB_OFF_RXDATA, 32'h5A);
    chk({31'h0, irq}, 32'h1);
    rdc(`UCB_OFF_ISTAT, 32'h03);
    @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    rdc(`UCB_OFF_CTRL, 32'hD5);
    t_rx(8'hF0, 9, 9'h033, 1'b1, 8'hF0);
    t_rx(8'hF0, 9, 9'h133, 1'b1, 8'hF5);
    t_rx(8'hC0, 9, 9'h133, 1'b1, 8'hC0);
    ap(1'b1, `UCB_OFF_PWR, 32'hC0);
    t_rx(8'h50, 9, 9'h111, 1'b0, 8'hD5);
    t_rx(8'hD0, 9, 9'h111, 1'b1, 8'hD5);
    ap(1'b1, `UCB_OFF_PWR, 32'h80);
  endtask
  task t_m1;
    t_rx(8'h50, 8, 9'h0C3, 1'b1, 8'h55);
    u_ucb_peer.send(96, 8, 9'h011, 1'b1);
    rdc(`UCB_OFF_RXDATA, 32'hC3);
    t_rx(8'h70, 8, 9'h0C3, 1'b0, 8'h70);
  endtask
  task t_cnt;
    t1_run <= 1'b1;
    ap(1'b1, `UCB_OFF_TIMER_MODE_REG, 32'h60);
    ap(1'b1, `UCB_OFF_CTRL, 32'h40);
    ap(1'b1, `UCB_OFF_TXDATA, 32'hA6);
    u_ucb_peer.recv(96, 8, d9);
    chk({23'h0, d9}, 32'h0A6);
    t1_run <= 1'b0;
  endtask
  task t_m0;
    int i;
    ap(1'b1, `UCB_OFF_CTRL, 32'h00);
    // Top bit zero, so a missing last bit cannot hide behind the idle level
    ap(1'b1, `UCB_OFF_TXDATA, 32'h69);
    wait (rxd_oe === 1'b1);
    repeat (9) @(posedge ref_clk);
    for (i = 0; i < 8; i++) begin
      b8[i] = rxd_in;
      repeat (6) @(posedge ref_clk);
    end
    chk({24'h0, b8}, 32'h69);
    wait (rxd_oe === 1'b0);
    rdc(`UCB_OFF_CTRL, 32'h02);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs;
    t_view;
    t_m2(1'b0, 8'h88, 8'hA5);
    t_m2(1'b1, 8'h80, 8'h3C);
    t_m3;
    t_m1;
    t_cnt;
    t_m0;
    close_out;
  end
endmodule // test_uart_control_and_baud_rate
bind ucb_uart ucb_uart_checker u_ucb_uart_checker (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .prdata, .pslverr, .rxd_in, .rxd_out, .rxd_oe, .txd, .t1_pin, .irq);
`default_nettype wire
